/* File: rtl/mpdp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mpdp_host #(
  parameter int unsigned DATA_W = mpdp_pkg::DATA_W
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESETN_I,
  input  wire logic              MODE_6800_I,
  input  wire logic              REQ_VALID_I,
  output logic                   REQ_READY_O,
  input  wire logic              REQ_READ_I,
  input  wire logic              REQ_IS_DATA_I,
  input  wire logic [DATA_W-1:0] REQ_WDATA_I,
  output logic                   RSP_VALID_O,
  output logic [DATA_W-1:0]      RSP_RDATA_O,
  output logic                   LCD_RESETN_O,
  output logic                   LCD_CMD_DATA_SELECT_O,
  output logic                   LCD_CSN_O,
  output logic                   LCD_WRN_E_O,
  output logic                   LCD_RDN_RW_O,
  input  wire logic [DATA_W-1:0] LCD_HOST_DATA_BUS_I,
  output logic [DATA_W-1:0]      LCD_HOST_DATA_BUS_O,
  output logic                   LCD_HOST_DATA_BUS_OE_O
);
  localparam int unsigned CW = mpdp_pkg::CNT_W;

  typedef struct packed {
    mpdp_pkg::mpdp_state_t st;
    logic                  rd;
    logic                  m68;
    logic                  sel;
    logic                  csn;
    logic                  wrn;
    logic                  rdn;
    logic                  oe;
    logic [DATA_W-1:0]     wdat;
    logic [DATA_W-1:0]     rdat;
    logic                  rvld;
    logic                  rstn;
  } mpdp_host_t;

  // ---------------------------------------------------------------------------
  // Value after reset: port idle, device held in reset
  // ---------------------------------------------------------------------------
  localparam mpdp_host_t RST_S = '{
    st   : mpdp_pkg::ST_IDLE,
    rd   : 1'b0,
    m68  : 1'b0,
    sel  : mpdp_pkg::SEL_DATA,
    csn  : 1'b1,
    wrn  : 1'b1,
    rdn  : 1'b1,
    oe   : 1'b0,
    wdat : '0,
    rdat : '0,
    rvld : 1'b0,
    rstn : 1'b0
  };

  mpdp_host_t s_q;
  mpdp_host_t s_d;
  logic       tmr_load;
  logic [CW-1:0] tmr_val;
  logic       tmr_done;

  function automatic logic [CW-1:0] cyc_f(input int unsigned n);
    cyc_f = CW'(n - 1);
  endfunction

  // ---------------------------------------------------------------------------
  // Timer loads and access steps
  // ---------------------------------------------------------------------------
  localparam logic [CW-1:0] LOAD_RD  = cyc_f(mpdp_pkg::FDRD_CYC);
  localparam logic [CW-1:0] LOAD_CSL = cyc_f(mpdp_pkg::PWCSL_CYC);
  localparam logic [CW-1:0] LOAD_CSH = cyc_f(mpdp_pkg::PWCSH_CYC);

  // First cycle of an access: chip select low, select and direction set up
  function automatic mpdp_host_t launch_f(
    input mpdp_host_t        s,
    input logic              m68,
    input logic              rd,
    input logic              is_data,
    input logic [DATA_W-1:0] wdat
  );
    launch_f      = s;
    launch_f.rd   = rd;
    launch_f.m68  = m68;
    launch_f.sel  = is_data ? mpdp_pkg::SEL_DATA : mpdp_pkg::SEL_COMMAND;
    launch_f.wdat = wdat;
    launch_f.oe   = !rd;
    launch_f.csn  = 1'b0;
    launch_f.rdn  = m68 ? rd : 1'b1;
    launch_f.wrn  = m68 ? 1'b0 : 1'b1;
    launch_f.st   = mpdp_pkg::ST_SETUP;
  endfunction

  // Last cycle: chip select released; in 6800 style the enable stays low
  // until the gap, so no rising edge meets chip select on its way up
  function automatic mpdp_host_t release_f(input mpdp_host_t s);
    release_f     = s;
    release_f.csn = 1'b1;
    release_f.wrn = s.m68 ? 1'b0 : 1'b1;
    release_f.rdn = 1'b1;
    release_f.oe  = 1'b0;
    release_f.st  = mpdp_pkg::ST_GAP;
  endfunction

  mpdp_timer #(
    .CNT_W (CW)
  ) u_timer (
    .CLK_SYS_I (CLK_SYS_I),
    .RESETN_I  (RESETN_I),
    .load_i    (tmr_load),
    .value_i   (tmr_val),
    .done_o    (tmr_done)
  );

  // ---------------------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------------------
  // IDLE, SETUP, STROBE, END, GAP: one bus word per pass
  always_comb begin
    s_d      = s_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    s_d.rvld = 1'b0;
    s_d.rstn = 1'b1;
    case (s_q.st)
      mpdp_pkg::ST_IDLE: begin
        // Nothing is taken before the device reset has been let go
        if (REQ_VALID_I && s_q.rstn) begin
          s_d = launch_f(s_d, MODE_6800_I, REQ_READ_I, REQ_IS_DATA_I, REQ_WDATA_I);
        end
      end
      mpdp_pkg::ST_SETUP: begin
        if (s_q.m68) begin
          s_d.wrn = 1'b1;
        end else if (s_q.rd) begin
          s_d.rdn = 1'b0;
        end else begin
          s_d.wrn = 1'b0;
        end
        tmr_load = 1'b1;
        tmr_val  = s_q.rd ? LOAD_RD : LOAD_CSL;
        s_d.st   = mpdp_pkg::ST_STROBE;
      end
      mpdp_pkg::ST_STROBE: begin
        if (tmr_done) begin
          if (s_q.rd) begin
            s_d.rdat = LCD_HOST_DATA_BUS_I;
            s_d.rvld = 1'b1;
          end
          if (s_q.m68) begin
            s_d.wrn = 1'b0;
          end else begin
            s_d.wrn = 1'b1;
            s_d.rdn = 1'b1;
          end
          s_d.st = mpdp_pkg::ST_END;
        end
      end
      mpdp_pkg::ST_END: begin
        s_d      = release_f(s_d);
        tmr_load = 1'b1;
        tmr_val  = LOAD_CSH;
      end
      mpdp_pkg::ST_GAP: begin
        // Enable may rise now: chip select has been high a full cycle
        s_d.wrn = 1'b1;
        if (tmr_done) begin
          s_d.st = mpdp_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = mpdp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Request side
  // ---------------------------------------------------------------------------
  assign REQ_READY_O            = (s_q.st == mpdp_pkg::ST_IDLE) && s_q.rstn;
  assign RSP_VALID_O            = s_q.rvld;
  assign RSP_RDATA_O            = s_q.rdat;

  // ---------------------------------------------------------------------------
  // Device pins
  // ---------------------------------------------------------------------------
  assign LCD_RESETN_O           = s_q.rstn;
  assign LCD_CMD_DATA_SELECT_O  = s_q.sel;
  assign LCD_CSN_O              = s_q.csn;
  assign LCD_WRN_E_O            = s_q.wrn;
  assign LCD_RDN_RW_O           = s_q.rdn;
  assign LCD_HOST_DATA_BUS_O    = s_q.wdat;
  assign LCD_HOST_DATA_BUS_OE_O = s_q.oe;
endmodule
`default_nettype wire

/* File: rtl/mpdp_pkg.sv */
package mpdp_pkg;
  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W = 18;

  // ---------------------------------------------------------------------------
  // Timing: device reference clock and host system clock
  // ---------------------------------------------------------------------------
  localparam int unsigned SYS_CLK_PERIOD_NS = 50;
  localparam int unsigned REF_CYC_MIN_NS    = 9;
  localparam int unsigned PWCSL_MIN_REF     = 1;
  localparam int unsigned PWCSH_MIN_REF     = 1;
  localparam int unsigned FDRD_MIN_REF      = 5;
  // Least times round up to whole system cycles, never below one
  localparam int unsigned PWCSL_CYC =
    ((PWCSL_MIN_REF * REF_CYC_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS) < 1 ? 1 :
    ((PWCSL_MIN_REF * REF_CYC_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
  localparam int unsigned PWCSH_CYC =
    ((PWCSH_MIN_REF * REF_CYC_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS) < 1 ? 1 :
    ((PWCSH_MIN_REF * REF_CYC_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
  localparam int unsigned FDRD_CYC =
    ((FDRD_MIN_REF * REF_CYC_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS) < 1 ? 1 :
    ((FDRD_MIN_REF * REF_CYC_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
  localparam int unsigned CNT_W = 4;

  // ---------------------------------------------------------------------------
  // Command codes and select levels
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_MEMORY_START = 8'h2C;
  localparam logic [7:0] CMD_READ_MEMORY_START  = 8'h2E;
  localparam logic       SEL_COMMAND            = 1'h0;
  localparam logic       SEL_DATA               = 1'h1;

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SETUP  = 5'h02,
    ST_STROBE = 5'h04,
    ST_END    = 5'h08,
    ST_GAP    = 5'h10
  } mpdp_state_t;
endpackage

/* File: rtl/mpdp_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module mpdp_timer #(
  parameter int unsigned CNT_W = 4
) (
  input  wire logic             CLK_SYS_I,
  input  wire logic             RESETN_I,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  done_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } mpdp_tmr_t;

  mpdp_tmr_t s_q;
  mpdp_tmr_t s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.cnt = value_i;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = (s_q.cnt == '0) && !load_i;
endmodule
`default_nettype wire

/* File: testbench/mpdp_props.sv */
`timescale 1ns/1ps
`default_nettype none
module mpdp_props (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic MODE_6800_I,
  input wire logic REQ_VALID_I,
  input wire logic REQ_READY_O,
  input wire logic REQ_READ_I,
  input wire logic REQ_IS_DATA_I,
  input wire logic RSP_VALID_O,
  input wire logic LCD_RESETN_O,
  input wire logic LCD_CMD_DATA_SELECT_O,
  input wire logic LCD_CSN_O,
  input wire logic LCD_WRN_E_O,
  input wire logic LCD_RDN_RW_O,
  input wire logic LCD_HOST_DATA_BUS_OE_O
);
  wire tk = REQ_VALID_I && REQ_READY_O;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  AST_IDLE: assert property (REQ_READY_O |-> LCD_CSN_O)
    else $error("select active while idle");
  AST_RSP: assert property (tk && REQ_READ_I |=> !RSP_VALID_O[*2] ##1 RSP_VALID_O ##1 !RSP_VALID_O)
    else $error("read answer late");
  AST_RST: assert property ($rose(RESETN_I) |-> !LCD_RESETN_O ##1 LCD_RESETN_O)
    else $error("device reset release wrong");
  AST_CSL: assert property ($fell(LCD_CSN_O) |-> !LCD_CSN_O[*3])
    else $error("select pulse short");
  AST_WR: assert property (tk && !REQ_READ_I && !MODE_6800_I |-> ##2 !LCD_WRN_E_O ##[1:2] LCD_WRN_E_O)
    else $error("write strobe missing");
  AST_E: assert property (tk && MODE_6800_I |-> ##1 !LCD_WRN_E_O ##1 LCD_WRN_E_O ##1 !LCD_WRN_E_O)
    else $error("enable rise missing");
  AST_EREL: assert property (MODE_6800_I && $rose(LCD_CSN_O) |-> !LCD_WRN_E_O)
    else $error("enable high as select releases");
  AST_CSH: assert property ($rose(LCD_CSN_O) |-> LCD_CSN_O[*2])
    else $error("select high time short");
  AST_OE: assert property (tk |=> LCD_HOST_DATA_BUS_OE_O == !$past(REQ_READ_I))
    else $error("bus drive wrong for direction");
  AST_RW: assert property (tk && MODE_6800_I |=> LCD_RDN_RW_O == $past(REQ_READ_I))
    else $error("direction level wrong");
  AST_SEL: assert property (tk |=> LCD_CMD_DATA_SELECT_O == $past(REQ_IS_DATA_I))
    else $error("select level wrong");
endmodule
bind mpdp_host mpdp_props u_mpdp_props (
  .CLK_SYS_I              (CLK_SYS_I),
  .RESETN_I               (RESETN_I),
  .MODE_6800_I            (MODE_6800_I),
  .REQ_VALID_I            (REQ_VALID_I),
  .REQ_READY_O            (REQ_READY_O),
  .REQ_READ_I             (REQ_READ_I),
  .REQ_IS_DATA_I          (REQ_IS_DATA_I),
  .RSP_VALID_O            (RSP_VALID_O),
  .LCD_RESETN_O           (LCD_RESETN_O),
  .LCD_CMD_DATA_SELECT_O  (LCD_CMD_DATA_SELECT_O),
  .LCD_CSN_O              (LCD_CSN_O),
  .LCD_WRN_E_O            (LCD_WRN_E_O),
  .LCD_RDN_RW_O           (LCD_RDN_RW_O),
  .LCD_HOST_DATA_BUS_OE_O (LCD_HOST_DATA_BUS_OE_O)
);
`default_nettype wire

/* File: testbench/mpdp_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mpdp_dev_model (
  input  wire logic        mode_i,
  input  wire logic        csn_i,
  input  wire logic        sel_i,
  input  wire logic        wrn_e_i,
  input  wire logic        rdn_rw_i,
  input  wire logic [17:0] dq_i,
  output logic      [17:0] dq_o
);
  logic [17:0] mem [16];
  int          wp = 0;
  int          rp = 0;
  logic        rd_ok = 1'b0;
  wire rd_act = !csn_i && (mode_i ? (rdn_rw_i && wrn_e_i) : !rdn_rw_i);
  // Released bus, or a word not yet due, shows the inverse
  assign dq_o = (rd_act && rd_ok) ? mem[rp[3:0]] : ~mem[rp[3:0]];
  always @(posedge wrn_e_i) begin
    if (!csn_i && !(mode_i && rdn_rw_i)) begin
      if (!sel_i) begin
        if (dq_i[7:0] == 8'h2C) wp = 0;
        if (dq_i[7:0] == 8'h2E) rp = 0;
      end else begin
        mem[wp[3:0]] = dq_i;
        wp++;
      end
    end
  end
  // Word is due after the first-read delay; a delivered read moves on
  always @(rd_act) begin
    if (!rd_act && rd_ok) rp++;
    rd_ok = 1'b0;
    if (rd_act) #(mpdp_pkg::FDRD_MIN_REF * mpdp_pkg::REF_CYC_MIN_NS) rd_ok = rd_act;
  end
endmodule
`default_nettype wire

/* File: testbench/mcu_parallel_display_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu_parallel_display_port_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        mode = 1'b0;
  logic        vld = 1'b0;
  logic        rd = 1'b0;
  logic        dat = 1'b0;
  logic [17:0] wd = 18'h00000;
  wire  logic  rdy, rsp, lrst, sel, csn, wre, rdrw, oe;
  wire  logic [17:0] rdat, hq, dq, bus;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [17:0] exp_q [$];
  assign bus = oe ? hq : dq;
  initial forever #25 clk = ~clk;
  mpdp_host u_mpdp_host (.CLK_SYS_I(clk), .RESETN_I(rstn), .MODE_6800_I(mode),
    .REQ_VALID_I(vld), .REQ_READY_O(rdy), .REQ_READ_I(rd), .REQ_IS_DATA_I(dat),
    .REQ_WDATA_I(wd), .RSP_VALID_O(rsp), .RSP_RDATA_O(rdat), .LCD_RESETN_O(lrst),
    .LCD_CMD_DATA_SELECT_O(sel), .LCD_CSN_O(csn), .LCD_WRN_E_O(wre),
    .LCD_RDN_RW_O(rdrw), .LCD_HOST_DATA_BUS_I(bus), .LCD_HOST_DATA_BUS_O(hq),
    .LCD_HOST_DATA_BUS_OE_O(oe));
  mpdp_dev_model u_mpdp_dev_model (.mode_i(mode), .csn_i(csn), .sel_i(sel),
    .wrn_e_i(wre), .rdn_rw_i(rdrw), .dq_i(bus), .dq_o(dq));
  task complete_run;
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Read requests carry the expected word in w
  task req(input logic r, input logic d, input logic [17:0] w);
    int n;
    vld <= 1'b1;
    rd <= r;
    dat <= d;
    wd <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    vld <= 1'b0;
    chk(18'(rdy), 18'h00001);
    if (r) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rsp !== 1'b1 && n < 20);
      chk(18'(rsp), 18'h00001);
      chk(rdat, w);
    end
    @(posedge clk);
  endtask
  initial begin
    logic [17:0] w;
    void'($urandom(32'h9f9f));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      req(1'b0, 1'b0, 18'h0002C);
      for (int i = 0; i < 5; i++) begin
        w = 18'($urandom);
        exp_q.push_back(w);
        req(1'b0, 1'b1, w);
      end
      req(1'b0, 1'b0, 18'h0002E);
      for (int i = 0; i < 5; i++) req(1'b1, 1'b1, exp_q.pop_front());
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(18'(lrst), 18'h00000);
    chk(18'(csn), 18'h00001);
    complete_run;
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
